/* File: spi_eeprom_command_status.sv */
`timescale 1ns/1ps
module spi_eeprom_command_status #(
   parameter spi_eeprom_pkg::variant_type variant           = spi_eeprom_pkg::VARIANT_512,
   parameter int                          write_cycle_count = spi_eeprom_pkg::WRITE_CYCLE_COUNT
) (
   input  wire logic                                  clock,
   input  wire logic                                  rst,
   input  wire logic                                  sck,
   input  wire logic                                  cs_n,
   input  wire logic                                  si,
   input  wire logic                                  wp_n,
   output logic                                       so,
   output logic                                       so_oe,
   output logic                                       ready_busy_flag,
   output logic                                       write_latch_flag,
   output logic      [1:0]                            protect_level,
   output logic                                       write_launch,
   output logic      [spi_eeprom_pkg::ADDR_WIDTH-1:0] write_addr
);
   import spi_eeprom_pkg::*;

   // ----------------------------------------------------------------
   // link side: serial receive on rising sck
   // ----------------------------------------------------------------
   // counter is cleared by deselect; capture registers are not, so the
   // core can still read them after the frame has ended
   logic [BIT_COUNT_WIDTH-1:0] bit_cnt;
   logic [BIT_COUNT_WIDTH-1:0] next_bit_cnt;
   logic [BIT_COUNT_WIDTH-1:0] total_bits;
   logic [6:0]                 rx_shift;
   logic [6:0]                 next_rx_shift;
   logic [OPCODE_WIDTH-1:0]    opcode;
   logic [OPCODE_WIDTH-1:0]    next_opcode;
   logic [7:0]                 second_byte;
   logic [7:0]                 next_second_byte;
   logic                       frame_tog = 1'b0;
   logic                       next_frame_tog;

   always_comb begin
      next_rx_shift    = {rx_shift[5:0], si};
      next_bit_cnt     = (bit_cnt == BIT_COUNT_MAX) ? bit_cnt : bit_cnt + 7'h01;
      next_frame_tog   = (bit_cnt == 7'h00) ? ~frame_tog : frame_tog;
      next_opcode      = (bit_cnt == BITS_OPCODE - 7'h01) ? {rx_shift, si} : opcode;
      next_second_byte = (bit_cnt == BITS_TWO_BYTES - 7'h01) ? {rx_shift, si} : second_byte;
   end

   // a rising select clears the count, so every frame starts from bit zero
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt <= 7'h00;
      end else begin
         bit_cnt <= next_bit_cnt;
      end
   end

   always_ff @(posedge sck) begin
      rx_shift    <= next_rx_shift;
      total_bits  <= next_bit_cnt;
      opcode      <= next_opcode;
      second_byte <= next_second_byte;
      frame_tog   <= next_frame_tog;
   end

   // ----------------------------------------------------------------
   // link side: status out on falling sck
   // ----------------------------------------------------------------
   logic [3:0] status_link;
   logic [7:0] status_byte;
   logic [6:0] out_shift;
   logic [6:0] next_out_shift;
   logic       so_bit;
   logic       next_so_bit;
   logic       so_drive;
   logic       next_so_drive;

   // busy, latch and protect bits are slow; a few sck edges of the
   // opcode are enough to settle the synchroniser
   spi_eeprom_sync #(
      .WIDTH(4)
   ) u_status_sync (
      .clock    (sck),
      .async_in ({protect_level, write_latch_flag, ready_busy_flag}),
      .sync_out (status_link)
   );

   always_comb begin
      status_byte                             = 8'h00;
      status_byte[STAT_BUSY]                  = status_link[0];
      status_byte[STAT_LATCH]                 = status_link[1];
      status_byte[STAT_BP_MSB:STAT_BP_LSB]    = status_link[3:2];
      status_byte[7:STAT_SPARE_LSB]           = {4{status_link[0]}};
   end

   // unknown opcodes never enable the output
   always_comb begin
      next_out_shift = {out_shift[5:0], 1'b0};
      next_so_bit    = out_shift[6];
      next_so_drive  = 1'b0;
      if (bit_cnt >= BITS_OPCODE && decode_opcode(opcode) == CMD_STATUS_READ) begin
         next_so_drive = 1'b1;
         if (bit_cnt[2:0] == 3'h0) begin
            next_so_bit    = status_byte[7];
            next_out_shift = status_byte[6:0];
         end
      end
   end

   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         out_shift <= 7'h00;
         so_bit    <= 1'b0;
         so_drive  <= 1'b0;
      end else begin
         out_shift <= next_out_shift;
         so_bit    <= next_so_bit;
         so_drive  <= next_so_drive;
      end
   end

   assign so    = so_bit;
   assign so_oe = so_drive;

   // ----------------------------------------------------------------
   // core side: frame end detection
   // ----------------------------------------------------------------
   // capture registers are only read after the synchronised deselect
   // and a changed frame toggle, when they have stood still for
   // at least two core cycles
   logic       cs_s;
   logic       wp_s;
   logic       tog_s;
   logic       cs_prev;
   logic       next_cs_prev;
   logic       seen_tog;
   logic       next_seen_tog;
   logic       wp_low_seen;
   logic       next_wp_low_seen;
   logic       frame_end;
   logic       wp_ok;
   cmd_type    cmd;
   logic       blocked;
   logic [ADDR_WIDTH-1:0] array_addr;

   spi_eeprom_sync #(
      .WIDTH(3)
   ) u_core_sync (
      .clock    (clock),
      .async_in ({cs_n, wp_n, frame_tog}),
      .sync_out ({cs_s, wp_s, tog_s})
   );

   spi_eeprom_protect_check u_protect (
      .raw_addr      ({opcode[OPCODE_TOP_ADDR], second_byte}),
      .protect_level (protect_level),
      .variant       (variant),
      .array_addr    (array_addr),
      .blocked       (blocked)
   );

   always_comb begin
      cmd              = decode_opcode(opcode);
      frame_end        = cs_s & ~cs_prev & (tog_s != seen_tog);
      next_cs_prev     = cs_s;
      next_seen_tog    = frame_end ? tog_s : seen_tog;
      next_wp_low_seen = wp_low_seen;
      if (cs_prev & ~cs_s) begin
         next_wp_low_seen = ~wp_s;
      end else if (~cs_s & ~wp_s) begin
         next_wp_low_seen = 1'b1;
      end
      wp_ok = wp_s & ~wp_low_seen;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cs_prev     <= 1'b1;
         seen_tog    <= tog_s;
         wp_low_seen <= 1'b0;
      end else begin
         cs_prev     <= next_cs_prev;
         seen_tog    <= next_seen_tog;
         wp_low_seen <= next_wp_low_seen;
      end
   end

   // ----------------------------------------------------------------
   // core side: command execution and write cycle timer
   // ----------------------------------------------------------------
   core_state_type         state;
   core_state_type         next_state;
   logic [TIMER_WIDTH-1:0] timer;
   logic [TIMER_WIDTH-1:0] next_timer;
   logic                   next_busy;
   logic                   next_wel;
   logic [1:0]             next_bp;
   logic                   next_launch;
   logic [ADDR_WIDTH-1:0]  next_write_addr;
   logic                   write_frame_ok;

   // protect bits model nonvolatile cells: no reset, only a shipped value
   logic [1:0] bp_store = BP_DEFAULT;

   always_comb begin
      write_frame_ok  = (total_bits >= BITS_WRITE_MIN)
                        && ((total_bits[2:0] == 3'h0) || (total_bits == BIT_COUNT_MAX));
      next_state      = state;
      next_timer      = timer;
      next_wel        = write_latch_flag;
      next_bp         = bp_store;
      next_launch     = 1'b0;
      next_write_addr = write_addr;
      case (state)
         ST_IDLE: begin
            if (frame_end) begin
               case (cmd)
                  CMD_SET_LATCH: begin
                     if (total_bits == BITS_OPCODE && wp_ok) begin
                        next_wel = 1'b1;
                     end
                  end
                  CMD_CLEAR_LATCH: begin
                     if (total_bits == BITS_OPCODE) begin
                        next_wel = 1'b0;
                     end
                  end
                  CMD_STATUS_WRITE: begin
                     // no latch, no cycle and no change
                     if (total_bits == BITS_TWO_BYTES && write_latch_flag && wp_ok) begin
                        next_bp    = second_byte[STAT_BP_MSB:STAT_BP_LSB];
                        next_state = ST_STATUS_CYCLE;
                        next_timer = TIMER_WIDTH'(write_cycle_count - 1);
                     end
                  end
                  CMD_ARRAY_WRITE: begin
                     if (write_frame_ok && write_latch_flag && wp_ok && !blocked) begin
                        next_launch     = 1'b1;
                        next_write_addr = array_addr;
                        next_state      = ST_ARRAY_CYCLE;
                        next_timer      = TIMER_WIDTH'(write_cycle_count - 1);
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_STATUS_CYCLE, ST_ARRAY_CYCLE: begin
            // frames other than status read finish unseen here
            if (timer == '0) begin
               next_state = ST_IDLE;
               next_wel   = 1'b0;
            end else begin
               next_timer = timer - 1'b1;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      next_busy = (next_state != ST_IDLE);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state            <= ST_IDLE;
         timer            <= '0;
         ready_busy_flag  <= 1'b0;
         write_latch_flag <= 1'b0;
         write_launch     <= 1'b0;
         write_addr       <= '0;
      end else begin
         state            <= next_state;
         timer            <= next_timer;
         ready_busy_flag  <= next_busy;
         write_latch_flag <= next_wel;
         write_launch     <= next_launch;
         write_addr       <= next_write_addr;
      end
   end

   // kept out of reset so a reset does not disturb the stored level
   always_ff @(posedge clock) begin
      bp_store <= next_bp;
   end

   assign protect_level = bp_store;

endmodule // spi_eeprom_command_status

/* File: spi_eeprom_command_status_sva.sv */
`timescale 1ns/1ps
module spi_eeprom_command_status_sva
   import spi_eeprom_pkg::*;
#(
   parameter int write_cycle_count = 20
) (
   input wire logic                  clock,
   input wire logic                  rst,
   input wire logic                  cs_n,
   input wire logic                  so,
   input wire logic                  so_oe,
   input wire logic                  ready_busy_flag,
   input wire logic                  write_latch_flag,
   input wire logic [1:0]            protect_level,
   input wire logic                  write_launch,
   input wire logic [ADDR_WIDTH-1:0] write_addr
);
   // ----------------------------------------------------------------
   // busy length counter
   // ----------------------------------------------------------------
   int busy_cycles;
   int next_busy_cycles;
   always_comb begin
      next_busy_cycles = ready_busy_flag ? busy_cycles + 1 : 0;
   end
   always_ff @(posedge clock) begin
      busy_cycles <= rst ? 0 : next_busy_cycles;
   end

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   so_idle_a: assert property (cs_n && $past(cs_n) |-> !so_oe && so == 1'b0)
      else $error("serial output active while deselected");
   busy_length_a: assert property ($fell(ready_busy_flag) |->
      busy_cycles >= write_cycle_count && busy_cycles <= write_cycle_count + 1)
      else $error("write cycle length wrong");
   latch_end_a: assert property ($fell(ready_busy_flag) |-> !write_latch_flag)
      else $error("latch not cleared at cycle end");
   busy_frozen_a: assert property (ready_busy_flag && $past(ready_busy_flag)
      |-> $stable(protect_level) && $stable(write_latch_flag))
      else $error("state changed during write cycle");
   launch_busy_a: assert property (write_launch |-> ##[0:1] ready_busy_flag)
      else $error("launch without busy");
   launch_latch_a: assert property (write_launch |-> write_latch_flag)
      else $error("launch without latch");
   addr_hold_a: assert property (!write_launch |-> $stable(write_addr))
      else $error("write address moved without launch");
   protect_cycle_a: assert property ($changed(protect_level) |-> ##[0:1] ready_busy_flag)
      else $error("protect change without write cycle");
   busy_deselect_a: assert property ($rose(ready_busy_flag) |-> $past(cs_n))
      else $error("cycle launched while selected");
   latch_rise_a: assert property ($rose(write_latch_flag) |-> $past(cs_n) && !$past(ready_busy_flag))
      else $error("latch set at wrong time");

   cover property ($rose(ready_busy_flag) && !write_launch);
   cover property (write_launch);
   cover property ($rose(so_oe));
endmodule // spi_eeprom_command_status_sva

bind spi_eeprom_command_status spi_eeprom_command_status_sva #(
   .write_cycle_count(write_cycle_count)
) checker_inst (
   .clock(clock),
   .rst(rst),
   .cs_n(cs_n),
   .so(so),
   .so_oe(so_oe),
   .ready_busy_flag(ready_busy_flag),
   .write_latch_flag(write_latch_flag),
   .protect_level(protect_level),
   .write_launch(write_launch),
   .write_addr(write_addr)
);

/* File: spi_eeprom_command_status_test.sv */
`timescale 1ns/1ps
module spi_eeprom_command_status_test;
   import spi_eeprom_pkg::*;
   localparam int cycles = 1000;
   logic                  clock;
   logic                  rst;
   logic                  wp_n;
   logic                  sck;
   logic                  cs_n;
   logic                  si;
   logic                  so;
   logic                  so_oe;
   logic                  ready_busy_flag;
   logic                  write_latch_flag;
   logic [1:0]            protect_level;
   logic                  write_launch;
   logic [ADDR_WIDTH-1:0] write_addr;
   logic [7:0]            rd_byte;
   logic                  rd_done;
   logic                  oe_seen;
   logic [7:0]            junk;
   logic [8:0]            a;
   logic [8:0]            addr_tbl [4][2];
   logic                  ok_tbl [4][2];
   logic [7:0]            stat_q [$];
   logic [8:0]            addr_q [$];
   int                    bad_count;
   int                    cmp_count;
   int                    seed;
   int                    tick;

   spi_eeprom_command_status #(.write_cycle_count(cycles)) DUT (
      .clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe),
      .ready_busy_flag(ready_busy_flag), .write_latch_flag(write_latch_flag), .protect_level(protect_level),
      .write_launch(write_launch), .write_addr(write_addr));
   spi_master_model link (
      .sck(sck), .cs_n(cs_n), .si(si), .rd_done(rd_done), .rd_byte(rd_byte), .oe_seen(oe_seen),
      .so(so), .so_oe(so_oe));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
         bad_count++;
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic frame(input logic [23:0] d, input int n);
      link.xfer(d, n);
      repeat (12) @(posedge clock);
   endtask

   task automatic rd_status(input logic [7:0] exp);
      stat_q.push_back(exp);
      frame(24'h050000, 16);
   endtask

   task automatic wait_idle();
      int k;
      for (k = 0; k < 2000 && ready_busy_flag !== 1'b0; k++) @(posedge clock);
      // a write cycle that never ends counts as a mismatch
      if (k == 2000) bad_count++;
      repeat (2) @(posedge clock);
   endtask

   // ----------------------------------------------------------------
   // result watchers
   // ----------------------------------------------------------------
   always @(posedge rd_done) begin
      check("status byte", {1'b0, rd_byte}, stat_q.size() > 0 ? {1'b0, stat_q.pop_front()} : 9'hxxx);
   end
   // sampled mid-cycle, away from the edge that launches the pulse
   always @(negedge clock) begin
      if (write_launch === 1'b1) begin
         check("launch address", write_addr, addr_q.size() > 0 ? addr_q.pop_front() : 9'hxxx);
      end
      tick++;
      if (tick > 60000) begin
         bad_count++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 9664;
      bad_count = 0;
      cmp_count = 0;
      tick = 0;
      rst = 1'b1;
      wp_n = 1'b1;
      addr_tbl = '{'{9'h1ff, 9'h000}, '{9'h17f, 9'h180}, '{9'h0ff, 9'h100}, '{9'h000, 9'h1ff}};
      ok_tbl = '{'{1'b1, 1'b1}, '{1'b1, 1'b0}, '{1'b1, 1'b0}, '{1'b0, 1'b0}};
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      rd_status(8'h00);
      frame(24'h0e0000, 8);
      check("latch after set", write_latch_flag, 1'b1);
      rd_status(8'h02);
      wp_n <= 1'b0;
      frame(24'h0c0000, 8);
      check("latch after clear", write_latch_flag, 1'b0);
      frame(24'h060000, 8);
      check("latch with guard low", write_latch_flag, 1'b0);
      wp_n <= 1'b1;
      frame(24'h010c00, 16);
      check("protect without latch", protect_level, 2'h0);
      check("busy without latch", ready_busy_flag, 1'b0);
      frame(24'h0a1055, 24); // array write with latch clear must not launch
      frame(24'hf50000, 16);
      check("output on bad opcode", oe_seen, 1'b0);
      for (int lvl = 0; lvl < 4; lvl++) begin
         junk = $random(seed);
         frame(24'h060000, 8);
         frame({8'h01, junk[7:4], lvl[1:0], junk[1:0], 8'h00}, 16);
         rd_status({4'hf, lvl[1:0], 2'b11});
         frame(24'h040000, 8);
         check("latch held while busy", write_latch_flag, 1'b1);
         wait_idle();
         check("latch after status cycle", write_latch_flag, 1'b0);
         check("protect level", protect_level, lvl[1:0]);
         rd_status({4'h0, lvl[1:0], 2'b00});
         for (int j = 0; j < 2; j++) begin
            a = addr_tbl[lvl][j];
            junk = $random(seed);
            frame(24'h060000, 8);
            if (ok_tbl[lvl][j]) addr_q.push_back(a);
            frame({4'h0, a[8], 3'b010, a[7:0], junk}, 24);
            wait_idle();
            check("latch after array write", write_latch_flag, !ok_tbl[lvl][j]);
         end
      end
      rst <= 1'b1;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      check("protect kept over reset", protect_level, 2'h3);
      rd_status(8'h0c);
      check("status notes left", stat_q.size(), 9'h000);
      check("launch notes left", addr_q.size(), 9'h000);
      close_out();
   end
endmodule // spi_eeprom_command_status_test

/* File: spi_eeprom_pkg.sv */
// Contract
// - eight-bit instruction register takes first byte
// - msb first, frame starts at select fall
// - 0000x110 sets write latch at deselect
// - 0000x100 clears latch, write guard ignored
// - 05h shifts status out after opcode
// - status/array writes need latch set first
// - array opcodes carry top address in bit3
// - status bit0 shows internal operation busy
// - status bit1 mirrors latch, not writable
// - bits 7:4 zero idle, ones busy
// - protect level 00 none to 11 all
// - status write changes only bits 3:2
// - protect bits survive power loss
// - during write cycle only status read
// - status write cycle end clears latch
// - status write cycle starts at deselect
// - level1 blocks upper quarter of array
// - level2 blocks upper half of array
// - level3 blocks the whole array
// - power-up leaves write latch cleared
// - unknown opcode: no data, output floats
// - array write cycle end clears latch
package spi_eeprom_pkg;

   // ----------------------------------------------------------------
   // opcode decode
   // ----------------------------------------------------------------
   localparam int         OPCODE_WIDTH       = 8;
   localparam int         OPCODE_TOP_ADDR    = 3;
   localparam logic [3:0] OPCODE_HIGH_NIBBLE = 4'h0;
   localparam logic [2:0] LOW_SET_LATCH      = 3'h6;
   localparam logic [2:0] LOW_CLEAR_LATCH    = 3'h4;
   localparam logic [2:0] LOW_STATUS_READ    = 3'h5;
   localparam logic [2:0] LOW_STATUS_WRITE   = 3'h1;
   localparam logic [2:0] LOW_ARRAY_READ     = 3'h3;
   localparam logic [2:0] LOW_ARRAY_WRITE    = 3'h2;

   typedef enum logic [2:0] {
      CMD_INVALID,
      CMD_SET_LATCH,
      CMD_CLEAR_LATCH,
      CMD_STATUS_READ,
      CMD_STATUS_WRITE,
      CMD_ARRAY_READ,
      CMD_ARRAY_WRITE
   } cmd_type;

   function automatic cmd_type decode_opcode(input logic [OPCODE_WIDTH-1:0] op);
      cmd_type c;
      c = CMD_INVALID;
      if (op[7:4] == OPCODE_HIGH_NIBBLE) begin
         case (op[2:0])
            LOW_SET_LATCH:    c = CMD_SET_LATCH;
            LOW_CLEAR_LATCH:  c = CMD_CLEAR_LATCH;
            LOW_STATUS_READ:  c = CMD_STATUS_READ;
            LOW_STATUS_WRITE: c = CMD_STATUS_WRITE;
            LOW_ARRAY_READ:   c = CMD_ARRAY_READ;
            LOW_ARRAY_WRITE:  c = CMD_ARRAY_WRITE;
            default:          c = CMD_INVALID;
         endcase
      end
      return c;
   endfunction

   // ----------------------------------------------------------------
   // frame lengths in serial bits
   // ----------------------------------------------------------------
   localparam int             BIT_COUNT_WIDTH = 7;
   localparam logic [6:0]     BIT_COUNT_MAX   = 7'h7f;
   localparam logic [6:0]     BITS_OPCODE     = 7'h08;
   localparam logic [6:0]     BITS_TWO_BYTES  = 7'h10;
   localparam logic [6:0]     BITS_WRITE_MIN  = 7'h18;

   // ----------------------------------------------------------------
   // status register layout
   // ----------------------------------------------------------------
   localparam int         STAT_BUSY      = 0;
   localparam int         STAT_LATCH     = 1;
   localparam int         STAT_BP_LSB    = 2;
   localparam int         STAT_BP_MSB    = 3;
   localparam int         STAT_SPARE_LSB = 4;
   localparam logic [1:0] BP_DEFAULT     = 2'h0;
   localparam logic [1:0] BP_NONE        = 2'h0;
   localparam logic [1:0] BP_QUARTER     = 2'h1;
   localparam logic [1:0] BP_HALF        = 2'h2;
   localparam logic [1:0] BP_ALL         = 2'h3;

   // ----------------------------------------------------------------
   // array variants and addressing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      VARIANT_128,
      VARIANT_256,
      VARIANT_512
   } variant_type;

   localparam int ADDR_WIDTH = 9;

   // ----------------------------------------------------------------
   // self-timed write cycle
   // ----------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS   = 4;
   localparam int WRITE_CYCLE_NS    = 5000000;
   localparam int WRITE_CYCLE_COUNT = WRITE_CYCLE_NS / CLOCK_PERIOD_NS;
   localparam int TIMER_WIDTH       = 21;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_STATUS_CYCLE,
      ST_ARRAY_CYCLE
   } core_state_type;

endpackage

/* File: spi_eeprom_protect_check.sv */
`timescale 1ns/1ps
module spi_eeprom_protect_check
   import spi_eeprom_pkg::*;
(
   input  wire logic        [ADDR_WIDTH-1:0] raw_addr,
   input  wire logic        [1:0]            protect_level,
   input  wire variant_type                  variant,
   output logic             [ADDR_WIDTH-1:0] array_addr,
   output logic                              blocked
);

   logic [1:0] top_bits;

   always_comb begin
      case (variant)
         VARIANT_128: begin
            array_addr = {2'h0, raw_addr[6:0]};
            top_bits   = raw_addr[6:5];
         end
         VARIANT_256: begin
            array_addr = {1'b0, raw_addr[7:0]};
            top_bits   = raw_addr[7:6];
         end
         default: begin
            array_addr = raw_addr;
            top_bits   = raw_addr[8:7];
         end
      endcase
      case (protect_level)
         BP_QUARTER: blocked = (top_bits == 2'h3);
         BP_HALF:    blocked = top_bits[1];
         BP_ALL:     blocked = 1'b1;
         default:    blocked = 1'b0;
      endcase
   end

endmodule // spi_eeprom_protect_check

/* File: spi_eeprom_sync.sv */
`timescale 1ns/1ps
module spi_eeprom_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // first stage feeds only the second one
   always_ff @(posedge clock) begin
      stage1   <= async_in;
      sync_out <= stage1;
   end

endmodule // spi_eeprom_sync

/* File: spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
   output logic       sck,
   output logic       cs_n,
   output logic       si,
   output logic       rd_done,
   output logic [7:0] rd_byte,
   output logic       oe_seen,
   input wire logic   so,
   input wire logic   so_oe
);
   initial begin
      sck = 1'b0;
      si = 1'b0;
      rd_done = 1'b0;
      rd_byte = 8'h00;
      oe_seen = 1'b0;
      // raised after time zero so the select edge surely clears the link counters
      #1 cs_n = 1'b1;
   end

   // left-aligned frame; sck idles low outside frames
   task automatic xfer(input logic [23:0] d, input int n);
      int i;
      #13.3;
      cs_n = 1'b0;
      oe_seen = 1'b0;
      for (i = 0; i < n; i++) begin
         #20 si = d[23-i];
         #20 sck = 1'b1;
         oe_seen = oe_seen | so_oe;
         if (i >= 8 && i < 16) rd_byte = {rd_byte[6:0], so};
         #40 sck = 1'b0;
      end
      #20 cs_n = 1'b1;
      // released line must not keep its last value
      si = ~si;
      if (d[23:20] == 4'h0 && d[18:16] == 3'h5) begin
         rd_done = 1'b1;
         #1 rd_done = 1'b0;
      end
   endtask
endmodule // spi_master_model
